/* File: logic/ldi_host.sv */
// Bus controller that addresses and transfers registers of the LED driver
//
// Contract
// - Bus clock at most 100 kHz, 400 kHz or 1 MHz per speed grade.
// - Transmitter changes the data line only while the clock is low.
// - Data falling with clock high is START; rising is STOP.
// - Only the controller makes START and STOP; bus busy between them.
// - Repeated START behaves as a first START and restarts addressing.
// - Controller clocks each acknowledge pulse and releases data during it; on reads it drives data low except on the last byte.
// - Reading controller leaves data high on the last byte's acknowledge.
// - Every byte is eight bits, most significant bit first.
// - First byte: chip address 7..3, register bits 9..8, direction bit 0.
// - Second byte carries register address bits 7..0.
// - Register address advances by one per data byte within a transfer.
module ldi_host
    import ldi_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire ldi_req_s req,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic [7:0] wr_data,
    input wire logic wr_valid,
    output logic wr_ready,
    output ldi_rsp_s rsp,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe
);

    ldi_st_e st_r;
    ldi_st_e st_nxt;
    ldi_seg_e seg_r;
    ldi_seg_e seg_nxt;
    logic [1:0] q_r;
    logic [1:0] q_nxt;
    logic [4:0] tick_r;
    logic [4:0] tick_nxt;
    logic [3:0] bit_r;
    logic [3:0] bit_nxt;
    logic [7:0] sh_r;
    logic [7:0] sh_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic nack_r;
    logic nack_nxt;
    ldi_req_s req_r;
    ldi_req_s req_nxt;
    ldi_rsp_s rsp_r;
    ldi_rsp_s rsp_nxt;
    logic scl_oe_r;
    logic scl_oe_nxt;
    logic sda_oe_r;
    logic sda_oe_nxt;
    logic scl_s;
    logic sda_s;
    logic stall;
    logic phase_end;
    logic byte_end;
    logic [4:0] qlen;

    ldi_sync u_scl_sync (
        .mclk(mclk),
        .rstn(rstn),
        .d(scl_i),
        .q(scl_s)
    );

    ldi_sync u_sda_sync (
        .mclk(mclk),
        .rstn(rstn),
        .d(sda_i),
        .q(sda_s)
    );

    // Quarter period of the captured speed grade
    always_comb
    begin
        unique case (req_r.speed)
            LDI_FAST: qlen = Q_FAST_CYC;
            LDI_FP: qlen = Q_FP_CYC;
            default: qlen = Q_STD_CYC;
        endcase
    end

    // Hold the high phase while a target stretches the clock
    assign stall = (st_r != ST_IDLE) && (st_r != ST_WAIT)
        && (q_r == Q_HIGH_A) && !scl_s;
    assign phase_end = (tick_r == TICK_RST) && !stall;
    assign byte_end = (st_r == ST_BIT) && phase_end && (q_r == Q_LOW_B)
        && (bit_r == ACK_BIT);

    always_comb
    begin
        st_nxt = st_r;
        seg_nxt = seg_r;
        q_nxt = q_r;
        tick_nxt = tick_r;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        cnt_nxt = cnt_r;
        nack_nxt = nack_r;
        req_nxt = req_r;
        rsp_nxt = rsp_r;
        rsp_nxt.done = 1'h0;
        rsp_nxt.rd_valid = 1'h0;
        if (st_r != ST_IDLE && st_r != ST_WAIT)
        begin
            if (tick_r != TICK_RST)
                tick_nxt = tick_r - 5'h01;
            else if (!stall)
            begin
                tick_nxt = qlen - 5'h01;
                q_nxt = q_r + 2'h1;
            end
        end
        unique case (st_r)
            ST_IDLE:
            begin
                if (req_valid)
                begin
                    req_nxt = req;
                    seg_nxt = SG_A1;
                    st_nxt = ST_START;
                    q_nxt = Q_LOW_A;
                    tick_nxt = TICK_RST;
                    cnt_nxt = req.len;
                    rsp_nxt.err = 1'h0;
                end
            end
            ST_START:
            begin
                if (phase_end && q_r == Q_LOW_B)
                begin
                    st_nxt = ST_BIT;
                    bit_nxt = 4'h0;
                    sh_nxt = {req_r.chip, req_r.reg_addr[9:8],
                        (seg_r == SG_A1R) ? RW_READ : RW_WRITE};
                end
            end
            ST_BIT:
            begin
                if (phase_end && q_r == Q_HIGH_B)
                begin
                    if (bit_r == ACK_BIT)
                        nack_nxt = sda_s;
                    else if (seg_r == SG_RD)
                        sh_nxt = {sh_r[6:0], sda_s};
                end
                if (phase_end && q_r == Q_LOW_B && bit_r != ACK_BIT)
                begin
                    bit_nxt = bit_r + 4'h1;
                    if (seg_r != SG_RD)
                        sh_nxt = {sh_r[6:0], 1'h0};
                end
                if (byte_end)
                begin
                    bit_nxt = 4'h0;
                    if (nack_r && seg_r != SG_RD)
                    begin
                        rsp_nxt.err = 1'h1;
                        st_nxt = ST_STOP;
                    end
                    else
                    begin
                        unique case (seg_r)
                            SG_A1:
                            begin
                                seg_nxt = SG_A2;
                                sh_nxt = req_r.reg_addr[7:0];
                            end
                            SG_A2:
                            begin
                                if (req_r.read)
                                begin
                                    seg_nxt = SG_A1R;
                                    st_nxt = ST_START;
                                end
                                else
                                begin
                                    seg_nxt = SG_WR;
                                    st_nxt = ST_WAIT;
                                end
                            end
                            SG_A1R:
                                seg_nxt = SG_RD;
                            SG_WR:
                            begin
                                if (cnt_r == CNT_RST)
                                    st_nxt = ST_STOP;
                                else
                                begin
                                    cnt_nxt = cnt_r - 4'h1;
                                    st_nxt = ST_WAIT;
                                end
                            end
                            SG_RD:
                            begin
                                rsp_nxt.rd_valid = 1'h1;
                                rsp_nxt.rd_data = sh_r;
                                if (cnt_r == CNT_RST)
                                    st_nxt = ST_STOP;
                                else
                                    cnt_nxt = cnt_r - 4'h1;
                            end
                        endcase
                    end
                end
            end
            ST_WAIT:
            begin
                if (wr_valid)
                begin
                    sh_nxt = wr_data;
                    st_nxt = ST_BIT;
                    bit_nxt = 4'h0;
                    q_nxt = Q_LOW_A;
                    tick_nxt = qlen - 5'h01;
                end
            end
            ST_STOP:
            begin
                if (phase_end && q_r == Q_LOW_B)
                begin
                    st_nxt = ST_IDLE;
                    rsp_nxt.done = 1'h1;
                end
            end
        endcase
        // Pin drive, registered one cycle after the phase that asks for it
        scl_oe_nxt = 1'h0;
        sda_oe_nxt = 1'h0;
        unique case (st_r)
            ST_IDLE:
            begin
                scl_oe_nxt = 1'h0;
                sda_oe_nxt = 1'h0;
            end
            ST_START:
            begin
                scl_oe_nxt = (q_r == Q_LOW_B)
                    || (q_r == Q_LOW_A && seg_r == SG_A1R);
                sda_oe_nxt = q_r[1];
            end
            ST_BIT:
            begin
                scl_oe_nxt = (q_r == Q_LOW_A) || (q_r == Q_LOW_B);
                if (bit_r == ACK_BIT)
                    sda_oe_nxt = (seg_r == SG_RD)
                        && (cnt_r != CNT_RST);
                else
                    sda_oe_nxt = (seg_r != SG_RD) && !sh_r[7];
            end
            ST_WAIT:
            begin
                scl_oe_nxt = 1'h1;
                sda_oe_nxt = 1'h0;
            end
            ST_STOP:
            begin
                scl_oe_nxt = (q_r == Q_LOW_A);
                sda_oe_nxt = !q_r[1];
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            st_r <= ST_IDLE;
            seg_r <= SG_A1;
            q_r <= Q_LOW_A;
            tick_r <= TICK_RST;
            bit_r <= 4'h0;
            sh_r <= BYTE_RST;
            cnt_r <= CNT_RST;
            nack_r <= 1'h0;
            req_r <= '0;
            rsp_r <= '0;
            scl_oe_r <= 1'h0;
            sda_oe_r <= 1'h0;
        end
        else
        begin
            st_r <= st_nxt;
            seg_r <= seg_nxt;
            q_r <= q_nxt;
            tick_r <= tick_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            cnt_r <= cnt_nxt;
            nack_r <= nack_nxt;
            req_r <= req_nxt;
            rsp_r <= rsp_nxt;
            scl_oe_r <= scl_oe_nxt;
            sda_oe_r <= sda_oe_nxt;
        end
    end

    assign req_ready = (st_r == ST_IDLE);
    assign wr_ready = (st_r == ST_WAIT);
    assign rsp = rsp_r;
    assign scl_o = 1'h0;
    assign sda_o = 1'h0;
    assign scl_oe = scl_oe_r;
    assign sda_oe = sda_oe_r;

    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);

    sda_hold_a: assert property (
        $changed(sda_oe_r) && !scl_oe_r
        |-> ($past(st_r) == ST_START) || ($past(st_r) == ST_STOP))
        else $error("data line moved while clock high outside START/STOP");

    start_edge_a: assert property (
        $rose(sda_oe_r) && !scl_oe_r |-> $past(st_r) == ST_START)
        else $error("data fell with clock high outside START");

    stop_edge_a: assert property (
        $fell(sda_oe_r) && !scl_oe_r |-> $past(st_r) == ST_STOP)
        else $error("data rose with clock high outside STOP");

    ack_release_a: assert property (
        st_r == ST_BIT && bit_r == ACK_BIT && seg_r != SG_RD
        |=> !sda_oe_r)
        else $error("data line driven during write acknowledge");

    last_nack_a: assert property (
        st_r == ST_BIT && bit_r == ACK_BIT && seg_r == SG_RD
        |=> sda_oe_r == $past(cnt_r != CNT_RST))
        else $error("wrong acknowledge on read byte");

    msb_first_a: assert property (
        st_r == ST_BIT && bit_r != ACK_BIT && seg_r != SG_RD
        |=> sda_oe_r == !$past(sh_r[7]))
        else $error("transmitted bit is not the shift register top bit");

    byte1_fmt_a: assert property (
        st_r == ST_START && phase_end && q_r == Q_LOW_B
        |=> sh_r == {req_r.chip, req_r.reg_addr[9:8], seg_r == SG_A1R})
        else $error("first address byte layout wrong");

    byte2_fmt_a: assert property (
        byte_end && seg_r == SG_A1 && !nack_r
        |=> sh_r == req_r.reg_addr[7:0] && seg_r == SG_A2)
        else $error("second address byte not loaded");

    rep_start_a: assert property (
        byte_end && seg_r == SG_A2 && !nack_r && req_r.read
        |=> st_r == ST_START && seg_r == SG_A1R ##1 !sda_oe_r)
        else $error("read did not continue with repeated START");

    count_step_a: assert property (
        byte_end && (seg_r == SG_WR || seg_r == SG_RD) && !nack_r
        && cnt_r != CNT_RST |=> cnt_r == $past(cnt_r) - 4'h1)
        else $error("byte count did not advance by one");

    quarter_a: assert property (
        $changed(q_r) && st_r != ST_IDLE && $past(st_r) != ST_WAIT
        && $past(st_r) != ST_IDLE |-> $past(tick_r) == TICK_RST)
        else $error("bus clock phase ended early");

    write_done_c: cover property (
        rsp_r.done && !rsp_r.err && !req_r.read);
    read_done_c: cover property (
        rsp_r.done && !rsp_r.err && req_r.read);
    nack_err_c: cover property (rsp_r.done && rsp_r.err);
    stretch_c: cover property (stall ##1 !stall);

endmodule

/* File: logic/ldi_pkg.sv */
// Constants, types and timing for the LED driver bus controller
package ldi_pkg;

    // System clock
    localparam int unsigned CLK_NS = 100;

    // Shortest bus clock period per speed grade, in ns
    localparam int unsigned T_STD_NS = 10000;
    localparam int unsigned T_FAST_NS = 2500;
    localparam int unsigned T_FP_NS = 1000;

    // Quarter bus clock period in mclk cycles, rounded up
    localparam logic [4:0] Q_STD_CYC =
        5'((T_STD_NS / 4 + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0] Q_FAST_CYC =
        5'((T_FAST_NS / 4 + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0] Q_FP_CYC =
        5'((T_FP_NS / 4 + CLK_NS - 1) / CLK_NS);

    // First address byte layout
    localparam int unsigned CHIP_MSB = 7;
    localparam int unsigned CHIP_LSB = 3;
    localparam int unsigned RA_HI_MSB = 2;
    localparam int unsigned RA_HI_LSB = 1;
    localparam int unsigned RW_POS = 0;
    localparam logic [2:0] IND_PREFIX = 3'h5;
    localparam logic [4:0] BCAST_CHIP = 5'h1b;
    localparam logic RW_READ = 1'h1;
    localparam logic RW_WRITE = 1'h0;

    // Bit positions within a byte slot and quarter phases
    localparam logic [3:0] ACK_BIT = 4'h8;
    localparam logic [1:0] Q_LOW_A = 2'h0;
    localparam logic [1:0] Q_HIGH_A = 2'h1;
    localparam logic [1:0] Q_HIGH_B = 2'h2;
    localparam logic [1:0] Q_LOW_B = 2'h3;

    // Reset values
    localparam logic [3:0] CNT_RST = 4'h0;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [4:0] TICK_RST = 5'h00;

    typedef enum logic [1:0] {
        LDI_STD = 2'h0,
        LDI_FAST = 2'h1,
        LDI_FP = 2'h2
    } ldi_speed_e;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_START = 5'h02,
        ST_BIT = 5'h04,
        ST_WAIT = 5'h08,
        ST_STOP = 5'h10
    } ldi_st_e;

    typedef enum logic [4:0] {
        SG_A1 = 5'h01,
        SG_A2 = 5'h02,
        SG_A1R = 5'h04,
        SG_WR = 5'h08,
        SG_RD = 5'h10
    } ldi_seg_e;

    typedef struct packed {
        logic [4:0] chip;
        logic [9:0] reg_addr;
        logic read;
        logic [3:0] len;
        ldi_speed_e speed;
    } ldi_req_s;

    typedef struct packed {
        logic done;
        logic err;
        logic rd_valid;
        logic [7:0] rd_data;
    } ldi_rsp_s;

    // Individual chip address for one of the four variants
    function automatic logic [4:0] ldi_chip(input logic [1:0] variant);
        return {IND_PREFIX, variant};
    endfunction

endpackage

/* File: logic/ldi_sync.sv */
// Two flip-flop synchroniser for a bus pin
module ldi_sync
    import ldi_pkg::*;
(
    input wire logic mclk,
    input wire logic rstn,
    input wire logic d,
    output logic q
);

    logic meta_r;
    logic meta_nxt;
    logic q_r;
    logic q_nxt;

    always_comb
    begin
        meta_nxt = d;
        q_nxt = meta_r;
    end

    // Idle bus level is high
    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_r <= 1'h1;
            q_r <= 1'h1;
        end
        else
        begin
            meta_r <= meta_nxt;
            q_r <= q_nxt;
        end
    end

    assign q = q_r;

endmodule

/* File: test/ldi_dev_model.sv */
// Behavioural LED driver target on the two-wire bus
module ldi_dev_model
    import ldi_pkg::*;
#(
    parameter logic [1:0] VARIANT = 2'h1
)
(
    input wire logic scl,
    input wire logic sda,
    input wire logic nack_data,
    input wire logic stretch,
    output logic sda_oe,
    output logic scl_oe
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:1023];
    logic [7:0] sh = 8'h00;
    logic [9:0] ra = 10'h000;
    logic host_ack = 1'b0;
    logic rd = 1'b0;
    logic a = 1'b0;
    int ph = 0;
    int cnt = 0;

    initial
    begin
        sda_oe = 1'b0;
        scl_oe = 1'b0;
    end

    // Start and repeated start both restart addressing
    always @(negedge sda)
        if (scl === 1'b1)
        begin
            ph = 1;
            // The clock fall that closes the start is not a bit
            cnt = -1;
        end

    always @(posedge sda)
        if (scl === 1'b1)
            ph = 0;

    always @(posedge scl)
        if (ph != 0 && cnt < 8 && ph != 4)
            sh = {sh[6:0], sda};
        else if (ph == 4 && cnt == 8)
            host_ack = !sda;

    // Data line moves only well after the falling clock edge
    always @(negedge scl)
        if (ph != 0)
        begin
            cnt = cnt + 1;
            if (cnt == 8)
            begin
                case (ph)
                    1: a = sh[7:3] == {IND_PREFIX, VARIANT}
                        || sh[7:3] == BCAST_CHIP;
                    2: a = 1'b1;
                    3: a = !nack_data;
                    default: a = 1'b0;
                endcase
                if (ph == 1)
                    rd = sh[0];
                if (ph == 1 && sh[0] == RW_WRITE)
                    ra[9:8] = sh[2:1];
                if (ph == 2)
                    ra[7:0] = sh;
                if (ph == 3 && a)
                begin
                    mem[ra] = sh;
                    ra = ra + 10'h001;
                end
                if (ph != 4 && !a)
                    ph = 0;
                sda_oe <= #50 a;
            end
            else if (cnt == 9)
            begin
                cnt = 0;
                if (stretch)
                begin
                    scl_oe = 1'b1;
                    scl_oe <= #3000 1'b0;
                end
                if (ph == 1)
                    ph = rd ? 4 : 2;
                else if (ph == 2)
                    ph = 3;
                else if (ph == 4 && !host_ack)
                    ph = 0;
                if (ph == 4)
                begin
                    sh = mem[ra];
                    ra = ra + 10'h001;
                end
                sda_oe <= #50 (ph == 4) && !sh[7];
            end
            else if (ph == 4)
                sda_oe <= #50 !sh[7 - cnt];
        end
endmodule

/* File: test/tb.sv */
// Self-checking bench for the LED driver bus controller
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ldi_pkg::*;

    typedef struct {
        ldi_req_s r;
        logic err;
        logic slow;
    } ldi_row_s;

    logic mclk, rstn, req_valid, wr_valid, nack_data, stretch;
    logic req_ready, wr_ready, scl_oe, sda_oe, scl_o, sda_o;
    logic m1_sda, m1_scl, m2_sda, m2_scl;
    logic [7:0] wr_data, msh;
    ldi_req_s req;
    ldi_rsp_s rsp;
    wire logic scl = !(scl_oe | m1_scl | m2_scl);
    wire logic sda = !(sda_oe | m1_sda | m2_sda);
    int fail_count = 0;
    int num_checks = 0;
    int starts, stops, n;
    int bitc = 20;
    logic [7:0] rdq[$], b1q[$], b2q[$];
    time last_rise, min_per;

    ldi_row_s rows [9] = '{
        '{'{5'h15, 10'h3fc, 1'b0, 4'h2, LDI_STD}, 1'b0, 1'b0},
        '{'{5'h15, 10'h3fc, 1'b1, 4'h2, LDI_FAST}, 1'b0, 1'b1},
        '{'{5'h1b, 10'h155, 1'b0, 4'h1, LDI_FP}, 1'b0, 1'b0},
        '{'{5'h16, 10'h155, 1'b1, 4'h1, LDI_FP}, 1'b0, 1'b0},
        '{'{5'h15, 10'h156, 1'b1, 4'h0, ldi_speed_e'(2'h3)}, 1'b0, 1'b0},
        '{'{5'h16, 10'h200, 1'b0, 4'hf, LDI_FP}, 1'b0, 1'b0},
        '{'{5'h16, 10'h200, 1'b1, 4'hf, LDI_FAST}, 1'b0, 1'b0},
        '{'{5'h17, 10'h0a0, 1'b0, 4'h0, LDI_FAST}, 1'b1, 1'b0},
        '{'{5'h0d, 10'h0a0, 1'b0, 4'h0, LDI_FAST}, 1'b1, 1'b0}
    };

    ldi_host i_dut (.mclk(mclk), .rstn(rstn), .req(req),
        .req_valid(req_valid), .req_ready(req_ready), .wr_data(wr_data),
        .wr_valid(wr_valid), .wr_ready(wr_ready), .rsp(rsp), .scl_i(scl),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda), .sda_o(sda_o),
        .sda_oe(sda_oe));
    ldi_dev_model #(.VARIANT(2'h1)) i_dev1 (.scl(scl), .sda(sda),
        .nack_data(nack_data), .stretch(stretch), .sda_oe(m1_sda),
        .scl_oe(m1_scl));
    ldi_dev_model #(.VARIANT(2'h2)) i_dev2 (.scl(scl), .sda(sda),
        .nack_data(1'b0), .stretch(1'b0), .sda_oe(m2_sda),
        .scl_oe(m2_scl));

    initial
    begin
        mclk = 1'b0;
        forever #50 mclk = !mclk;
    end

    // Wire monitor: frame counts, first two bytes, clock period
    always @(negedge sda)
        if (scl === 1'b1)
        begin
            starts++;
            bitc = 0;
        end
    always @(posedge sda)
        if (scl === 1'b1)
            stops++;
    always @(posedge scl)
    begin
        if (last_rise != 0 && $time - last_rise < min_per)
            min_per = $time - last_rise;
        last_rise = $time;
        if (bitc == 8)
            chk("ack release", 8'h00, {7'h00, sda_oe});
        msh = {msh[6:0], sda};
        if (bitc == 7)
            b1q.push_back(msh);
        if (bitc == 16)
            b2q.push_back(msh);
        if (bitc < 20)
            bitc++;
    end

    function automatic logic [7:0] pat(input logic [9:0] a);
        return a[7:0] ^ {6'h00, a[9:8]} ^ 8'h3c;
    endfunction

    function automatic int unsigned lim(input ldi_speed_e s);
        return s == LDI_FAST ? T_FAST_NS : s == LDI_FP ? T_FP_NS : T_STD_NS;
    endfunction

    task automatic chk(input string what, input logic [7:0] exp,
        input logic [7:0] got);
        num_checks++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic chkn(input string what, input int exp, input int got);
        num_checks++;
        if (got != exp)
        begin
            fail_count++;
            $display("MISMATCH %s expected %0d seen %0d", what, exp, got);
        end
    endtask

    task automatic reset_chk();
        chk("idle scl", 8'h00, {7'h00, scl_oe});
        chk("idle sda", 8'h00, {7'h00, sda_oe});
        chk("idle ready", 8'h01, {7'h00, req_ready});
        chk("idle wr", 8'h00, {7'h00, wr_ready});
        chk("idle rsp", 8'h00, {7'h00, |rsp});
    endtask

    task automatic run(input ldi_req_s r, input logic err, input logic slow);
        int wi;
        logic d;
        wi = 0;
        d = 1'b0;
        n = 0;
        #10;
        rdq.delete();
        b1q.delete();
        b2q.delete();
        starts = 0;
        stops = 0;
        last_rise = 0;
        min_per = 1_000_000;
        stretch = slow;
        req = r;
        req_valid = 1'b1;
        do @(posedge mclk); while (req_ready !== 1'b1);
        #10 req_valid = 1'b0;
        while (!d && n < 20000)
        begin
            @(posedge mclk);
            n++;
            d = rsp.done === 1'b1;
            if (rsp.rd_valid === 1'b1)
                rdq.push_back(rsp.rd_data);
            if (wr_valid === 1'b1 && wr_ready === 1'b1)
                #10 wr_valid = 1'b0;
            else if (wr_ready === 1'b1 && wr_valid === 1'b0)
            begin
                #10 wr_data = pat(r.reg_addr + 10'(wi));
                wr_valid = 1'b1;
                wi++;
            end
        end
        chkn("done seen", 1, int'(d));
        chk("error flag", {7'h00, err}, {7'h00, rsp.err});
        chkn("read count", r.read && !err ? r.len + 1 : 0, rdq.size());
        foreach (rdq[i])
            chk("read byte", pat(r.reg_addr + 10'(i)), rdq[i]);
        chkn("stops", 1, stops);
        chkn("starts", r.read && !err ? 2 : 1, starts);
        chk("byte one", {r.chip, r.reg_addr[9:8], RW_WRITE},
            b1q[0]);
        if (!err)
            chk("byte two", r.reg_addr[7:0], b2q[0]);
        if (starts == 2)
            chk("read head", {r.chip, r.reg_addr[9:8], RW_READ},
                b1q[1]);
        chkn("bus period", 1, int'(min_per >= lim(r.speed)));
        $display("test end chip %h addr %h read %b", r.chip, r.reg_addr,
            r.read);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial
    begin
        #5_000_000;
        fail_count++;
        close_out();
    end

    initial
    begin
        rstn = 1'b0;
        req = '0;
        req_valid = 1'b0;
        wr_data = 8'h00;
        wr_valid = 1'b0;
        nack_data = 1'b0;
        stretch = 1'b0;
        repeat (6) @(posedge mclk);
        reset_chk();
        #10 rstn = 1'b1;
        $display("test end reset");
        foreach (rows[i])
            run(rows[i].r, rows[i].err, rows[i].slow);
        // Data byte refused, then a transfer right behind the abort
        nack_data = 1'b1;
        run('{5'h15, 10'h010, 1'b0, 4'h1, LDI_FAST}, 1'b1, 1'b0);
        nack_data = 1'b0;
        run('{5'h16, 10'h156, 1'b1, 4'h0, LDI_FP}, 1'b0, 1'b0);
        // Reset while the controller stalls for write data
        #10 req = '{5'h15, 10'h020, 1'b0, 4'h0, LDI_FP};
        req_valid = 1'b1;
        @(posedge mclk);
        #10 req_valid = 1'b0;
        n = 0;
        while (wr_ready !== 1'b1 && n < 5000)
        begin
            @(posedge mclk);
            n++;
        end
        #10 rstn = 1'b0;
        @(posedge mclk);
        #10 reset_chk();
        rstn = 1'b1;
        $display("test end mid reset");
        run('{5'h15, 10'h3fd, 1'b1, 4'h1, LDI_FP}, 1'b0, 1'b0);
        close_out();
    end
endmodule
